//--- rtl/twm_status.sv
module twm_status (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [twm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            irq,
    output twm_pkg::twm_eng_req_t           eng_req,
    input  wire twm_pkg::twm_eng_rsp_t      eng_rsp
);
    import twm_pkg::*;

    logic              cmd_v_r;
    logic [CMD_W-1:0]  cmd_r;
    logic              ncmd_v_r;
    logic [CMD_W-1:0]  ncmd_r;
    logic              busy_r;
    logic              tx_v_r;
    logic [BYTE_W-1:0] tx_r;
    logic              rx_v_r;
    logic [BYTE_W-1:0] rx_r;
    logic [N_EV-1:0]   ev_r;
    logic [N_EV-1:0]   ev_set;
    logic [N_EV-1:0]   ev_clr;
    logic [ST_W-1:0]   mask_r;
    logic [ST_W-1:0]   stat_w;
    logic [31:0]       prdata_nxt;
    logic              err_r;
    logic              setup;
    logic              acc;
    logic              wr;
    logic              rd;
    logic              take;
    logic              promote;
    logic              idle;

    // Address match, used by decode and by the access strobes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, OFF_CMD) | hit(a, OFF_NCMD) | hit(a, OFF_TXH) | hit(a, OFF_RXH) |
                 hit(a, OFF_STATUS) | hit(a, OFF_SCLR) | hit(a, OFF_MASK) | hit(a, OFF_VERSION);
    endfunction

    // Bus phases; access completes in its first cycle
    assign setup   = psel & ~penable;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & ~err_r;
    assign rd      = acc & ~pwrite & ~err_r;
    assign pready  = acc;
    assign pslverr = acc & err_r;

    // Engine pulls the current command; the queued one moves up behind it
    assign take    = eng_rsp.cmd_take & cmd_v_r;
    assign promote = ncmd_v_r & (~cmd_v_r | take);

    assign eng_req.cmd_valid = cmd_v_r;
    assign eng_req.cmd       = cmd_r;
    assign eng_req.tx_valid  = tx_v_r;
    assign eng_req.tx_byte   = tx_r;

    // Command slot; a write to a full slot is dropped, software polls the accept flag first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_v_r <= 1'b0;
            cmd_r   <= '0;
        end else if (promote) begin
            cmd_v_r <= 1'b1;
            cmd_r   <= ncmd_r;
        end else if (wr && hit(paddr, OFF_CMD) && (!cmd_v_r || take)) begin
            cmd_v_r <= 1'b1;
            cmd_r   <= pwdata;
        end else if (take) begin
            cmd_v_r <= 1'b0;
        end
    end

    // Next-command slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ncmd_v_r <= 1'b0;
            ncmd_r   <= '0;
        end else if (wr && hit(paddr, OFF_NCMD) && (!ncmd_v_r || promote)) begin
            ncmd_v_r <= 1'b1;
            ncmd_r   <= pwdata;
        end else if (promote) begin
            ncmd_v_r <= 1'b0;
        end
    end

    // Execution in progress from take to the engine's end pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else if (take) begin
            busy_r <= 1'b1;
        end else if (eng_rsp.cmd_end) begin
            busy_r <= 1'b0;
        end
    end

    // Transmit holding byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_v_r <= 1'b0;
            tx_r   <= '0;
        end else if (wr && hit(paddr, OFF_TXH) && !tx_v_r && !eng_rsp.tx_stopped) begin
            tx_v_r <= 1'b1;
            tx_r   <= pwdata[BYTE_W-1:0];
        end else if (eng_rsp.tx_take) begin
            tx_v_r <= 1'b0;
        end
    end

    // Receive holding byte; a new byte overwrites an unread one and flags overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_v_r <= 1'b0;
            rx_r   <= '0;
        end else if (eng_rsp.rx_put) begin
            rx_v_r <= 1'b1;
            rx_r   <= eng_rsp.rx_byte;
        end else if (rd && hit(paddr, OFF_RXH)) begin
            rx_v_r <= 1'b0;
        end
    end

    // Sticky events: done, fail, overrun
    assign ev_set[0] = busy_r & eng_rsp.cmd_end & ~eng_rsp.cmd_nak;  // [R2] [R3]
    assign ev_set[1] = busy_r & eng_rsp.cmd_end & eng_rsp.cmd_nak;
    assign ev_set[2] = eng_rsp.rx_put & rx_v_r & ~(rd & hit(paddr, OFF_RXH));
    assign ev_clr[0] = wr & hit(paddr, OFF_SCLR) & pwdata[ST_DONE];  // [R4]
    assign ev_clr[1] = wr & hit(paddr, OFF_SCLR) & pwdata[ST_FAIL];
    assign ev_clr[2] = wr & hit(paddr, OFF_SCLR) & pwdata[ST_OVRUN];

    // Set beats clear so an event in the clearing cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < N_EV; gi++) begin : g_ev
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ev_r[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    ev_r[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin  // [R4]
                    ev_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Live status word
    assign idle = ~busy_r & ~cmd_v_r & ~ncmd_v_r;  // [R1]
    always_comb begin
        stat_w            = '0;
        stat_w[ST_ACCEPT] = ~cmd_v_r | ~ncmd_v_r;              // [R5]
        stat_w[ST_TX_HOLDING_READY_FLAG]  = ~tx_v_r & ~eng_rsp.tx_stopped;     // [R6]
        stat_w[ST_RX_HOLDING_READY_FLAG]  = rx_v_r;                            // [R7]
        stat_w[ST_DONE]   = ev_r[0];
        stat_w[ST_IDLE]   = idle;
        stat_w[ST_FAIL]   = ev_r[1];
        stat_w[ST_OVRUN]  = ev_r[2];
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RST;
        end else if (wr && hit(paddr, OFF_MASK)) begin
            mask_r <= pwdata[ST_W-1:0];
        end
    end

    assign irq = |(stat_w & mask_r);

    // Read data captured in setup; status reads have no side effect
    always_comb begin
        prdata_nxt = '0;
        case (1'b1)
            hit(paddr, OFF_CMD):     prdata_nxt = cmd_r;
            hit(paddr, OFF_NCMD):    prdata_nxt = ncmd_r;
            hit(paddr, OFF_RXH):     prdata_nxt = {{(32-BYTE_W){1'b0}}, rx_r};
            hit(paddr, OFF_STATUS):  prdata_nxt = {{(32-ST_W){1'b0}}, stat_w};  // [R8]
            hit(paddr, OFF_MASK):    prdata_nxt = {{(32-ST_W){1'b0}}, mask_r};
            hit(paddr, OFF_VERSION): prdata_nxt = VERSION_VAL;
            default:                 prdata_nxt = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= PRDATA_RST;
            err_r  <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? PRDATA_RST : prdata_nxt;
            err_r  <= ~mapped(paddr);
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_cmd_ok;
    logic sclr_done;
    assign wr_cmd_ok = wr & hit(paddr, OFF_CMD) & ~cmd_v_r;
    assign sclr_done = wr & hit(paddr, OFF_SCLR) & pwdata[ST_DONE];

    idle_flag_a: assert property (wr_cmd_ok |=> !stat_w[ST_IDLE] ##1 !stat_w[ST_IDLE])  // [R1]
        else $error("idle high after a command was queued");
    done_set_a: assert property (busy_r && eng_rsp.cmd_end && !eng_rsp.cmd_nak |=> stat_w[ST_DONE])  // [R2]
        else $error("done flag not set on clean end");
    done_fail_a: assert property (busy_r && eng_rsp.cmd_end && eng_rsp.cmd_nak && !stat_w[ST_DONE]  // [R3]
                                  |=> !stat_w[ST_DONE] && stat_w[ST_FAIL])
        else $error("done flag set on failed command");
    done_clear_a: assert property (sclr_done && !ev_set[0] |=> !stat_w[ST_DONE])  // [R4]
        else $error("done flag survived clear");
    cmd_accept_a: assert property (cmd_v_r && ncmd_v_r |-> !stat_w[ST_ACCEPT])  // [R5]
        else $error("accept flag high with both slots full");
    cmd_full_a: assert property (!stat_w[ST_ACCEPT] && !take |=> $stable(cmd_r) && $stable(ncmd_r))  // [R5]
        else $error("full command slots changed without a take");
    tx_ready_a: assert property (wr && hit(paddr, OFF_TXH) && stat_w[ST_TX_HOLDING_READY_FLAG] && !eng_rsp.tx_take  // [R6]
                                 |=> !stat_w[ST_TX_HOLDING_READY_FLAG] && tx_r == $past(pwdata[BYTE_W-1:0]))
        else $error("tx ready not cleared by a byte");
    tx_stop_a: assert property (eng_rsp.tx_stopped |-> !stat_w[ST_TX_HOLDING_READY_FLAG])  // [R6]
        else $error("tx ready while stopped");
    rx_ready_a: assert property (eng_rsp.rx_put |=> stat_w[ST_RX_HOLDING_READY_FLAG] && rx_r == $past(eng_rsp.rx_byte))  // [R7]
        else $error("rx ready not set by a byte");
    rx_pop_a: assert property (rd && hit(paddr, OFF_RXH) && !eng_rsp.rx_put |=> !stat_w[ST_RX_HOLDING_READY_FLAG])  // [R7]
        else $error("rx ready not cleared by a read");
    status_read_a: assert property (rd && hit(paddr, OFF_STATUS) && ev_set == '0 |=> ev_r == $past(ev_r))  // [R8]
        else $error("status read changed a flag");

    // Helper terms for the persistence checks below
    logic clean_end;
    logic nak_end;
    logic rd_rxh;
    logic wr_slot;
    assign clean_end = busy_r & eng_rsp.cmd_end & ~eng_rsp.cmd_nak;
    assign nak_end   = busy_r & eng_rsp.cmd_end & eng_rsp.cmd_nak;
    assign rd_rxh    = rd & hit(paddr, OFF_RXH);
    assign wr_slot   = wr & (hit(paddr, OFF_CMD) | hit(paddr, OFF_NCMD));

    // Idle follows the engine: low from a take, back once nothing is left
    idle_take_a: assert property (take |=> !stat_w[ST_IDLE])  // [R1]
        else $error("idle high right after a take");
    idle_back_a: assert property ((clean_end || nak_end) && !cmd_v_r && !ncmd_v_r && !wr_slot  // [R1]
                                  |=> stat_w[ST_IDLE])
        else $error("idle low after the last command ended");

    // Sticky flags move only on their own event or on a write of one to the clear register
    done_hold_a: assert property (stat_w[ST_DONE] && !sclr_done |=> stat_w[ST_DONE])  // [R2]
        else $error("done flag lost without a clear");
    done_quiet_a: assert property (!stat_w[ST_DONE] && !clean_end |=> !stat_w[ST_DONE])  // [R3]
        else $error("done flag set without a clean end");
    fail_set_a: assert property (nak_end |=> stat_w[ST_FAIL])  // [R3]
        else $error("fail flag not set on a refused command");
    fail_hold_a: assert property (stat_w[ST_FAIL] && !(wr && hit(paddr, OFF_SCLR) && pwdata[ST_FAIL])  // [R3]
                                  |=> stat_w[ST_FAIL])
        else $error("fail flag lost without a clear");

    // Interrupt follows a done event one cycle later when done is unmasked
    irq_done_a: assert property (ev_set[0] && mask_r[ST_DONE] && !(wr && hit(paddr, OFF_MASK)) |=> irq)  // [R2]
        else $error("unmasked done event did not raise the interrupt");

    // Accept flag against the slot that a write or a take has just changed
    cmd_open_a: assert property (wr_cmd_ok && !ncmd_v_r |=> stat_w[ST_ACCEPT] && cmd_r == $past(pwdata))  // [R5]
        else $error("command write lost or accept dropped");
    ncmd_fill_a: assert property (wr && hit(paddr, OFF_NCMD) && cmd_v_r && !ncmd_v_r && !take  // [R5]
                                  |=> !stat_w[ST_ACCEPT])
        else $error("accept high with both slots filled");
    accept_take_a: assert property (take && !ncmd_v_r |=> stat_w[ST_ACCEPT])  // [R5]
        else $error("accept low after a take freed a slot");

    // Transmit ready tracks the byte slot and the stop level
    tx_hold_a: assert property (tx_v_r && !eng_rsp.tx_take |=> !stat_w[ST_TX_HOLDING_READY_FLAG])  // [R6]
        else $error("tx ready while a byte waits");
    tx_free_a: assert property (eng_rsp.tx_take && !wr |=> stat_w[ST_TX_HOLDING_READY_FLAG] || eng_rsp.tx_stopped)  // [R6]
        else $error("tx ready low after the byte left");

    // A waiting byte keeps receive ready up; a second one on top of it is an overrun
    rx_keep_a: assert property (stat_w[ST_RX_HOLDING_READY_FLAG] && !rd_rxh |=> stat_w[ST_RX_HOLDING_READY_FLAG])  // [R7]
        else $error("rx ready dropped with a byte unread");
    ovrun_set_a: assert property (eng_rsp.rx_put && stat_w[ST_RX_HOLDING_READY_FLAG] && !rd_rxh |=> stat_w[ST_OVRUN])  // [R7]
        else $error("overrun not flagged");

    // Status read returns the flags of its setup cycle; writes to it and bad addresses do nothing
    status_data_a: assert property (setup && !pwrite && hit(paddr, OFF_STATUS)  // [R8]
                                    |=> prdata == {{(32-ST_W){1'b0}}, $past(stat_w)})
        else $error("status read returned stale flags");
    status_ro_a: assert property (wr && hit(paddr, OFF_STATUS) && ev_set == '0  // [R8]
                                  |=> mask_r == $past(mask_r) && ev_r == $past(ev_r))
        else $error("status write changed a flag");
    bad_addr_a: assert property (acc && !mapped(paddr) |-> pslverr && prdata == '0)  // [R8]
        else $error("unmapped access not refused");
endmodule

//--- inc/twm_pkg.sv
// Overview of operation
// [R1] Idle reads one only when nothing executes and nothing waits in either command slot.
// [R2] Command done flag sets when the executing command ends without error.
// [R3] Command done flag stays zero when the command fails, e.g. on a not-acknowledge.
// [R4] Writing one to the done bit in the status clear register clears the flag.
// [R5] Command accept flag is one while either command slot can take a command.
// [R6] Tx holding ready is one while the byte slot is free and transmission runs.
// [R7] Rx holding ready is one while an unread received byte waits.
// [R8] All flags show in a read-only status register; reading it changes nothing.
package twm_pkg;
    localparam int ADDR_W = 8;
    localparam int CMD_W  = 32;
    localparam int BYTE_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CMD     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_NCMD    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TXH     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RXH     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SCLR    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_VERSION = 8'h1c;

    // Status bit positions; mask and clear share this layout
    localparam int ST_ACCEPT = 0;
    localparam int ST_TX_HOLDING_READY_FLAG  = 1;
    localparam int ST_RX_HOLDING_READY_FLAG  = 2;
    localparam int ST_DONE   = 3;
    localparam int ST_IDLE   = 4;
    localparam int ST_FAIL   = 8;
    localparam int ST_OVRUN  = 9;
    localparam int ST_W      = 10;
    localparam int N_EV      = 3;

    // Reset values
    localparam logic [ST_W-1:0]   MASK_RST    = 10'h000;
    localparam logic [31:0]       PRDATA_RST  = 32'h0000_0000;
    // Arbitrary identification value
    localparam logic [31:0]       VERSION_VAL = 32'h0000_0a5c;

    // Toward the serial engine of the master
    typedef struct packed {
        logic              cmd_valid;
        logic [CMD_W-1:0]  cmd;
        logic              tx_valid;
        logic [BYTE_W-1:0] tx_byte;
    } twm_eng_req_t;

    // From the serial engine, same clock
    typedef struct packed {
        logic              cmd_take;
        logic              cmd_end;
        logic              cmd_nak;
        logic              tx_take;
        logic              tx_stopped;
        logic              rx_put;
        logic [BYTE_W-1:0] rx_byte;
    } twm_eng_rsp_t;
endpackage

//--- bench/twm_eng_model.sv
module twm_eng_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire twm_pkg::twm_eng_req_t eng_req,
    output twm_pkg::twm_eng_rsp_t      eng_rsp,
    input  wire logic                  stall,
    input  wire logic                  nak_sel,
    input  wire logic                  stop,
    input  wire logic                  rx_go,
    input  wire logic [7:0]            rx_val
);
    timeunit 1ns;
    timeprecision 1ns;
    import twm_pkg::*;
    logic       busy_r;
    logic [1:0] cnt_r;
    // Command run is a fixed four cycles; stall holds off both takes so slots can fill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            cnt_r <= 2'h0;
            eng_rsp <= '0;
        end else begin
            eng_rsp.cmd_take <= !busy_r && eng_req.cmd_valid && !stall;
            eng_rsp.cmd_end <= busy_r && cnt_r == 2'h0;
            eng_rsp.cmd_nak <= busy_r && cnt_r == 2'h0 && nak_sel;
            if (!busy_r && eng_req.cmd_valid && !stall) begin
                busy_r <= 1'b1;
                cnt_r <= 2'h3;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 2'h1;
                busy_r <= cnt_r != 2'h0;
            end
            eng_rsp.tx_take <= eng_req.tx_valid && !stall && !eng_rsp.tx_take;
            eng_rsp.tx_stopped <= stop;
            eng_rsp.rx_put <= rx_go;
            // Byte lane toggles when idle so a stale value is never mistaken for data
            eng_rsp.rx_byte <= rx_go ? rx_val : ~eng_rsp.rx_byte;
        end
    end
endmodule

//--- bench/test_two_wire_master_status_flags.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t value mismatch", $time); end end
module test_two_wire_master_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import twm_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]   paddr, rx_val;
    logic [31:0]  pwdata, prdata, rd;
    logic         stall, nak_sel, stop, rx_go;
    twm_eng_req_t req;
    twm_eng_rsp_t rsp;
    int           fails, n_compared;

    twm_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .eng_req(req), .eng_rsp(rsp));
    twm_eng_model eng (.pclk(pclk), .presetn(presetn), .eng_req(req), .eng_rsp(rsp), .stall(stall),
        .nak_sel(nak_sel), .stop(stop), .rx_go(rx_go), .rx_val(rx_val));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic conclude();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            conclude();
        end
    endtask

    // Re-reads status until a bit takes a value; the bound stops a hang
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rd[b] !== v && n < 40);
        `CHK(rd[b], v)
        if (rd[b] !== v)
            conclude();
    endtask

    task automatic t_reset();
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h13)
        apb(1'b1, OFF_STATUS, 32'hffff_ffff);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h13)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        $display("reset test done");
    endtask

    task automatic t_cmd();
        stall <= 1'b1;
        apb(1'b1, OFF_MASK, 32'h1 << ST_DONE);
        apb(1'b1, OFF_CMD, 32'h0000_00a1);
        apb(1'b1, OFF_NCMD, 32'h0000_00a2);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_ACCEPT], 1'b0)
        `CHK(rd[ST_IDLE], 1'b0)
        stall <= 1'b0;
        poll(ST_IDLE, 1'b1);
        `CHK(rd[ST_DONE], 1'b1)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_DONE], 1'b1)
        `CHK(irq, 1'b1)
        apb(1'b1, OFF_SCLR, 32'h1 << ST_DONE);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_DONE], 1'b0)
        `CHK(rd[ST_ACCEPT], 1'b1)
        `CHK(irq, 1'b0)
        $display("command test done");
    endtask

    task automatic t_nak();
        nak_sel <= 1'b1;
        apb(1'b1, OFF_CMD, 32'h0000_00b1);
        poll(ST_IDLE, 1'b1);
        `CHK(rd[ST_DONE], 1'b0)
        `CHK(rd[ST_FAIL], 1'b1)
        nak_sel <= 1'b0;
        $display("nak test done");
    endtask

    task automatic t_txrx();
        stall <= 1'b1;
        apb(1'b1, OFF_TXH, 32'h0000_003c);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_TX_HOLDING_READY_FLAG], 1'b0)
        stall <= 1'b0;
        poll(ST_TX_HOLDING_READY_FLAG, 1'b1);
        stop <= 1'b1;
        poll(ST_TX_HOLDING_READY_FLAG, 1'b0);
        rx_go <= 1'b1;
        rx_val <= 8'h5a;
        @(posedge pclk);
        rx_go <= 1'b0;
        poll(ST_RX_HOLDING_READY_FLAG, 1'b1);
        apb(1'b0, OFF_RXH, 32'h0);
        `CHK(rd[7:0], 8'h5a)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_RX_HOLDING_READY_FLAG], 1'b0)
        $display("data test done");
    endtask

    // Registers not read elsewhere, and an overrun built from two unread bytes
    task automatic t_misc();
        apb(1'b0, OFF_VERSION, 32'h0);
        `CHK(rd, VERSION_VAL)
        `CHK(err, 1'b0)
        apb(1'b0, OFF_MASK, 32'h0);
        `CHK(rd, 32'h1 << ST_DONE)
        rx_go <= 1'b1;
        rx_val <= 8'h11;
        @(posedge pclk);
        rx_val <= 8'h22;
        @(posedge pclk);
        rx_go <= 1'b0;
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_OVRUN], 1'b1)
        `CHK(rd[ST_FAIL], 1'b1)
        apb(1'b0, OFF_RXH, 32'h0);
        `CHK(rd[7:0], 8'h22)
        apb(1'b1, OFF_SCLR, 32'h1 << ST_OVRUN);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[ST_OVRUN], 1'b0)
        `CHK(rd[ST_FAIL], 1'b1)
        $display("misc test done");
    endtask

    initial begin
        {psel, penable, pwrite, stall, nak_sel, stop, rx_go} = '0;
        {paddr, rx_val, pwdata} = '0;
        fails = 0;
        n_compared = 0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cmd();
        t_nak();
        t_txrx();
        t_misc();
        conclude();
    end
endmodule
